// File: common/bridge_status_params.svh
// offsets, field positions, reset values and timing counts of the status bank
`ifndef BRIDGE_STATUS_PARAMS_SVH
`define BRIDGE_STATUS_PARAMS_SVH

`define FRAME_BITS 5'h10
`define FIRST_BYTE_BITS 5'h08
`define BIT_COUNT_MAX 5'h11

`define ADDR_GENERAL_FAULT_SUMMARY 7'h0e
`define ADDR_SUPPLY_THERMAL_FAULTS 7'h0f
`define ADDR_DRAIN_SOURCE_FAULTS_WATCHDOG 7'h10
`define ADDR_INPUT_FAULTS_NODE_LEVELS 7'h11
`define ADDR_BACK_EMF_COMPARATORS 7'h12
`define ADDR_BACK_EMF_CONFIG 7'h2b

`define RESET_STATUS 8'h00
`define RESET_BACK_EMF_CONFIG 8'h00

`define GEN_CLEAR_MASK 8'h07
`define SUP_CLEAR_MASK 8'h7f
`define DS_CLEAR_MASK 8'h3f
`define IN_CLEAR_MASK 8'h38

`define GEN_BIT_DS_SUMMARY 6
`define GEN_BIT_SUP_SUMMARY 5
`define GEN_BIT_IN_SUMMARY 4
`define GEN_BIT_TEMP_SUMMARY 3
`define GEN_BIT_POR_CLEARED 2
`define GEN_BIT_STOP 1
`define GEN_BIT_SERIAL_ERROR 0
`define SUP_BIT_THERMAL_WARNING 6
`define SUP_BIT_THERMAL_SHUTDOWN 5
`define CFG_BIT_POSTPROCESS 2

`define CLOCK_PERIOD_NS 100
`define EMF_BLANK_00_US 6
`define EMF_BLANK_01_US 8
`define EMF_BLANK_10_US 12
`define EMF_BLANK_11_US 16
`define BLANK_CYCLES(us) (((us) * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// File: common/bridge_status_pkg.sv
// types shared by the status register bank
package bridge_status_pkg;

  typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_phase_t;

  // fault events from the analog monitors, high while present
  typedef struct packed {
    logic thermal_warning;
    logic thermal_shutdown;
    logic pump_one_undervoltage;
    logic pump_two_undervoltage;
    logic supply_hard_overvoltage;
    logic supply_config_overvoltage;
    logic supply_undervoltage;
    logic [5:0] drain_source;
  } fault_events_t;

  typedef struct packed {
    frame_phase_t phase;
    logic sclk_prev;
    logic [4:0] bit_count;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] snapshot;
    logic power_on_reset_cleared;
    logic stop_mode_flag;
    logic serial_protocol_error;
    logic [6:0] supply_faults;
    logic [5:0] drain_faults;
    logic [2:0] input_faults;
    logic emf_postprocess_enable;
    logic [1:0] emf_blanking_select;
    logic [2:0] emf_filtered;
    logic [2:0][7:0] emf_count;
  } status_state_t;

endpackage

// File: src/bridge_driver_status_regs.sv
// serial status and back-emf register bank of the three half-bridge driver
`timescale 1ns/1ns
`include "bridge_status_params.svh"

module bridge_driver_status_regs (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CSN,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire bridge_status_pkg::fault_events_t FAULT_EVENTS,
  input wire logic STOP_MODE_ACTIVE,
  input wire logic [1:0] WATCHDOG_PROGRESS,
  input wire logic [2:0] HIGH_CONTROL_INPUT,
  input wire logic [2:0] LOW_CONTROL_INPUT,
  input wire logic [2:0] NODE_ABOVE_LOW_THRESHOLD,
  input wire logic [2:0] EMF_COMPARATOR_RAW,
  input wire logic DRIVER_ENABLE_SETTING,
  input wire logic OVERVOLTAGE_REPORT_CONFIG,
  output logic EMF_POSTPROCESS_ENABLE,
  output logic [1:0] EMF_BLANKING_SELECT
);
  import bridge_status_pkg::*;

  status_state_t state_reg;
  status_state_t state_next;

  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic frame_good;
  logic frame_op;
  logic [6:0] frame_addr;
  logic clear_gen;
  logic clear_sup;
  logic clear_ds;
  logic clear_in;
  logic [7:0] clear_bits;
  logic [7:0] gen_view;
  logic [7:0] sup_view;
  logic [7:0] ds_view;
  logic [7:0] in_view;
  logic [7:0] emf_view;
  logic [7:0] cfg_view;
  logic [7:0] snap_value;
  logic [6:0] supply_set;
  logic [2:0] both_high;
  logic [2:0] node_view;
  logic [2:0] emf_source;
  logic [2:0] emf_filtered_next;
  logic [2:0][7:0] emf_count_next;
  logic [7:0] blank_limit;

  // frame decode; SCLK is sampled on CLOCK, so edges come from the previous sample
  assign sclk_rise = SCLK & ~state_reg.sclk_prev;
  assign sclk_fall = ~SCLK & state_reg.sclk_prev;
  assign frame_done = (state_reg.phase == FRAME_SHIFT) && CSN;
  assign frame_good = state_reg.bit_count == `FRAME_BITS;
  assign frame_addr = state_reg.shift_in[15:9];
  assign frame_op = state_reg.shift_in[8];

  // only an access bit of 1 on a whole frame clears; reads leave contents alone
  assign clear_gen = frame_done && frame_good && frame_op && frame_addr == `ADDR_GENERAL_FAULT_SUMMARY;
  assign clear_sup = frame_done && frame_good && frame_op && frame_addr == `ADDR_SUPPLY_THERMAL_FAULTS;
  assign clear_ds = frame_done && frame_good && frame_op && frame_addr == `ADDR_DRAIN_SOURCE_FAULTS_WATCHDOG;
  assign clear_in = frame_done && frame_good && frame_op && frame_addr == `ADDR_INPUT_FAULTS_NODE_LEVELS;
  // clearing uses the value already sent, so a flag raised after it stays set
  assign clear_bits = state_reg.snapshot;

  // configurable overvoltage is dropped when reporting is switched off
  assign supply_set = {FAULT_EVENTS.thermal_warning, FAULT_EVENTS.thermal_shutdown,
                       FAULT_EVENTS.pump_one_undervoltage, FAULT_EVENTS.pump_two_undervoltage,
                       FAULT_EVENTS.supply_hard_overvoltage,
                       FAULT_EVENTS.supply_config_overvoltage & ~OVERVOLTAGE_REPORT_CONFIG,
                       FAULT_EVENTS.supply_undervoltage};

  always_comb begin
    unique case (state_reg.emf_blanking_select)
      2'b00: blank_limit = 8'(`BLANK_CYCLES(`EMF_BLANK_00_US));
      2'b01: blank_limit = 8'(`BLANK_CYCLES(`EMF_BLANK_01_US));
      2'b10: blank_limit = 8'(`BLANK_CYCLES(`EMF_BLANK_10_US));
      2'b11: blank_limit = 8'(`BLANK_CYCLES(`EMF_BLANK_11_US));
    endcase
  end

  // per half-bridge: input conflict, node level and comparator blanking
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bridge
      assign both_high[i] = HIGH_CONTROL_INPUT[i] & LOW_CONTROL_INPUT[i];
      // level only meaningful with the bridge fully off
      assign node_view[i] = ~HIGH_CONTROL_INPUT[i] & ~LOW_CONTROL_INPUT[i] & NODE_ABOVE_LOW_THRESHOLD[i];
      // a comparator change is taken only after it has held for the blanking time
      always_comb begin
        if (EMF_COMPARATOR_RAW[i] == state_reg.emf_filtered[i]) begin
          emf_count_next[i] = 8'h00;
          emf_filtered_next[i] = state_reg.emf_filtered[i];
        end else if (state_reg.emf_count[i] + 8'h01 >= blank_limit) begin
          emf_count_next[i] = 8'h00;
          emf_filtered_next[i] = EMF_COMPARATOR_RAW[i];
        end else begin
          emf_count_next[i] = state_reg.emf_count[i] + 8'h01;
          emf_filtered_next[i] = state_reg.emf_filtered[i];
        end
      end
    end
  endgenerate

  assign emf_source = state_reg.emf_postprocess_enable ? state_reg.emf_filtered : EMF_COMPARATOR_RAW;

  // read views; reserved positions are tied to zero
  assign gen_view = {1'b0, |state_reg.drain_faults, |state_reg.supply_faults[4:0], |state_reg.input_faults,
                     state_reg.supply_faults[`SUP_BIT_THERMAL_WARNING] | state_reg.supply_faults[`SUP_BIT_THERMAL_SHUTDOWN],
                     state_reg.power_on_reset_cleared, state_reg.stop_mode_flag,
                     state_reg.serial_protocol_error};
  assign sup_view = {1'b0, state_reg.supply_faults};
  assign ds_view = {WATCHDOG_PROGRESS, state_reg.drain_faults};
  assign in_view = {2'b00, state_reg.input_faults, node_view};
  assign emf_view = {5'h00, DRIVER_ENABLE_SETTING ? emf_source : 3'b000};
  assign cfg_view = {5'h00, state_reg.emf_postprocess_enable, state_reg.emf_blanking_select};

  // register picked by the address byte, sampled when the first byte completes
  always_comb begin
    unique case (state_reg.shift_in[6:0])
      `ADDR_GENERAL_FAULT_SUMMARY: snap_value = gen_view;
      `ADDR_SUPPLY_THERMAL_FAULTS: snap_value = sup_view;
      `ADDR_DRAIN_SOURCE_FAULTS_WATCHDOG: snap_value = ds_view;
      `ADDR_INPUT_FAULTS_NODE_LEVELS: snap_value = in_view;
      `ADDR_BACK_EMF_COMPARATORS: snap_value = emf_view;
      `ADDR_BACK_EMF_CONFIG: snap_value = cfg_view;
      default: snap_value = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.sclk_prev = SCLK;

    // latched flags: set wins over a clear in the same cycle
    state_next.supply_faults = (state_reg.supply_faults & ~(clear_sup ? clear_bits[6:0] : 7'h00))
                               | supply_set;
    state_next.drain_faults = (state_reg.drain_faults & ~(clear_ds ? clear_bits[5:0] : 6'h00))
                              | FAULT_EVENTS.drain_source;
    state_next.input_faults = (state_reg.input_faults & ~(clear_in ? clear_bits[5:3] : 3'h0))
                              | {both_high[0], both_high[1], both_high[2]};
    state_next.stop_mode_flag = (state_reg.stop_mode_flag & ~(clear_gen & clear_bits[`GEN_BIT_STOP]))
                                | STOP_MODE_ACTIVE;
    state_next.serial_protocol_error = (state_reg.serial_protocol_error
                                        & ~(clear_gen & clear_bits[`GEN_BIT_SERIAL_ERROR]))
                                       | (frame_done & ~frame_good);
    if (clear_gen) begin
      state_next.power_on_reset_cleared = 1'b1;
    end
    state_next.emf_filtered = emf_filtered_next;
    state_next.emf_count = emf_count_next;

    unique case (state_reg.phase)
      FRAME_IDLE: begin
        if (!CSN) begin
          // first byte out is the general summary, as on most drivers of this kind
          state_next.phase = FRAME_SHIFT;
          state_next.bit_count = 5'h00;
          state_next.shift_out = gen_view;
          state_next.snapshot = 8'h00;
        end
      end
      FRAME_SHIFT: begin
        if (CSN) begin
          state_next.phase = FRAME_IDLE;
          if (frame_good && frame_op && frame_addr == `ADDR_BACK_EMF_CONFIG) begin
            state_next.emf_postprocess_enable = state_reg.shift_in[`CFG_BIT_POSTPROCESS];
            state_next.emf_blanking_select = state_reg.shift_in[1:0];
          end
        end else if (sclk_rise) begin
          state_next.shift_in = {state_reg.shift_in[14:0], SDI};
          if (state_reg.bit_count != `BIT_COUNT_MAX) begin
            state_next.bit_count = state_reg.bit_count + 5'h01;
          end
          if (state_reg.bit_count == `FIRST_BYTE_BITS - 5'h01) begin
            state_next.snapshot = snap_value;
          end
        end else if (sclk_fall) begin
          if (state_reg.bit_count == `FIRST_BYTE_BITS) begin
            state_next.shift_out = state_reg.snapshot;
          end else begin
            state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= '0;
      state_reg.phase <= FRAME_IDLE;
      state_reg.sclk_prev <= 1'b0;
      state_reg.power_on_reset_cleared <= 1'b0;
      state_reg.emf_postprocess_enable <= 1'(`RESET_BACK_EMF_CONFIG >> `CFG_BIT_POSTPROCESS);
      state_reg.emf_blanking_select <= 2'(`RESET_BACK_EMF_CONFIG);
      state_reg.supply_faults <= 7'(`RESET_STATUS);
    end else begin
      state_reg <= state_next;
    end
  end

  assign SDO = state_reg.shift_out[7];
  assign SDO_OE = state_reg.phase == FRAME_SHIFT;
  assign EMF_POSTPROCESS_ENABLE = state_reg.emf_postprocess_enable;
  assign EMF_BLANKING_SELECT = state_reg.emf_blanking_select;

  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  sequence s_bad_frame;
    frame_done && !frame_good;
  endsequence

  sequence s_sup_clear_quiet;
    clear_sup && supply_set == 7'h00;
  endsequence

  a_frame_length: assert property (s_bad_frame |=> state_reg.serial_protocol_error)
    else $error("short or long frame did not flag a protocol error");

  a_read_keeps: assert property (frame_done && frame_good && !frame_op && supply_set == 7'h00
                                 |=> $stable(state_reg.supply_faults))
    else $error("read frame changed supply flags");

  a_clear_whole: assert property (s_sup_clear_quiet
                                  |=> state_reg.supply_faults == ($past(state_reg.supply_faults)
                                                                 & ~$past(state_reg.snapshot[6:0])))
    else $error("clear did not drop the reported flags");

  a_flags_latched: assert property (!clear_ds |=> ($past(state_reg.drain_faults) & ~state_reg.drain_faults) == 6'h00)
    else $error("drain fault flag dropped without a clear");

  a_reserved_zero: assert property (cfg_view[7:3] == 5'h00 && in_view[7:6] == 2'b00 && gen_view[7] == 1'b0)
    else $error("reserved bit reads nonzero");

  a_raw_select: assert property (DRIVER_ENABLE_SETTING && !state_reg.emf_postprocess_enable
                                 |-> emf_view[2:0] == EMF_COMPARATOR_RAW)
    else $error("raw comparator not shown with processing off");

  a_blank_hold: assert property ($changed(state_reg.emf_filtered[0])
                                 |-> $past(state_reg.emf_count[0]) + 8'h01 >= $past(blank_limit))
    else $error("filtered comparator moved before blanking time");

  a_temp_summary: assert property (gen_view[`GEN_BIT_TEMP_SUMMARY]
                                   == (state_reg.supply_faults[6] | state_reg.supply_faults[5]))
    else $error("temperature summary disagrees with thermal flags");

  a_por_cleared: assert property (clear_gen |=> state_reg.power_on_reset_cleared [*2])
    else $error("power-on flag not set by clear");

  a_stop_flag: assert property (STOP_MODE_ACTIVE |=> state_reg.stop_mode_flag)
    else $error("stop flag not set in stop mode");

  a_input_fault: assert property (both_high[0] |=> state_reg.input_faults[2])
    else $error("bridge one input fault not latched");

  a_node_forced: assert property ((HIGH_CONTROL_INPUT[1] ^ LOW_CONTROL_INPUT[1]) |-> !in_view[1])
    else $error("node level shown with one control high");

  a_emf_gated: assert property (!DRIVER_ENABLE_SETTING |-> emf_view == 8'h00)
    else $error("comparator bits shown with driver disabled");

  a_ov_reported: assert property (FAULT_EVENTS.supply_config_overvoltage && !OVERVOLTAGE_REPORT_CONFIG
                                  |=> state_reg.supply_faults[1])
    else $error("configurable overvoltage not latched while reporting");

  a_ov_suppress: assert property (OVERVOLTAGE_REPORT_CONFIG && !state_reg.supply_faults[1]
                                  |=> !state_reg.supply_faults[1])
    else $error("configurable overvoltage flagged while suppressed");

endmodule

// File: dv/spi_master_model.sv
// serial master model that frames transfers into the status bank
`timescale 1ns/1ns
module spi_master_model (
  input wire logic CLOCK,
  output logic CSN,
  output logic SCLK,
  output logic SDI,
  input wire logic SDO
);
  initial begin
    CSN = 1'b1;
    SCLK = 1'b0;
    SDI = 1'b0;
  end
  // msb first, each clock phase three cycles; a short count gives a refused frame
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] got);
    got = 16'h0000;
    @(negedge CLOCK) CSN = 1'b0;
    repeat (3) @(negedge CLOCK);
    for (int i = 15; i > 15 - nbits; i--) begin
      SDI = word[i];
      repeat (3) @(negedge CLOCK);
      got[i] = SDO;
      SCLK = 1'b1;
      repeat (3) @(negedge CLOCK);
      SCLK = 1'b0;
    end
    repeat (3) @(negedge CLOCK);
    CSN = 1'b1;
    // idle data line must not look like the last bit
    SDI = ~SDI;
    repeat (2) @(negedge CLOCK);
  endtask
endmodule

// File: dv/tb_bridge_driver_status_regs.sv
// self-checking bench for the status register bank
`timescale 1ns/1ns
module tb_bridge_driver_status_regs;
  import bridge_status_pkg::*;
  logic clock, rstn, csn, sclk, sdi, sdo, sdo_oe, stop, drv_en, ov_cfg, pp_en;
  logic [1:0] wd, blank_sel;
  logic [2:0] hi, lo, node, emf;
  fault_events_t ev;
  logic [15:0] rx;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int blank[4] = '{60, 80, 120, 160};
  bridge_driver_status_regs u_bridge_driver_status_regs (.CLOCK(clock), .RSTN(rstn), .CSN(csn), .SCLK(sclk),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .FAULT_EVENTS(ev), .STOP_MODE_ACTIVE(stop), .WATCHDOG_PROGRESS(wd),
    .HIGH_CONTROL_INPUT(hi), .LOW_CONTROL_INPUT(lo), .NODE_ABOVE_LOW_THRESHOLD(node), .EMF_COMPARATOR_RAW(emf),
    .DRIVER_ENABLE_SETTING(drv_en), .OVERVOLTAGE_REPORT_CONFIG(ov_cfg), .EMF_POSTPROCESS_ENABLE(pp_en),
    .EMF_BLANKING_SELECT(blank_sel));
  spi_master_model u_spi_master_model (.CLOCK(clock), .CSN(csn), .SCLK(sclk), .SDI(sdi), .SDO(sdo));
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    u_spi_master_model.xfer({a, 1'b0, 8'h00}, 16, rx);
    chk($sformatf("read %h", a), exp, rx[7:0]);
  endtask
  task automatic clr(input logic [6:0] a, input logic [7:0] exp);
    u_spi_master_model.xfer({a, 1'b1, 8'h00}, 16, rx);
    chk($sformatf("clear %h", a), exp, rx[7:0]);
  endtask
  task automatic pulse(input fault_events_t f);
    @(negedge clock) ev = f;
    @(negedge clock) ev = '0;
  endtask
  task automatic t_reset();
    logic [6:0] regs[6] = '{7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h2b};
    foreach (regs[i]) rd(regs[i], 8'h00);
    chk("sdo enable idle", 8'h00, {7'h00, sdo_oe});
  endtask
  task automatic t_faults();
    logic [6:0] a;
    logic [7:0] e;
    for (int k = 0; k < 13; k++) begin
      pulse(13'h0001 << k);
      a = (k < 6) ? 7'h10 : 7'h0f;
      e = (k < 6) ? 8'h01 << k : 8'h01 << (k - 6);
      rd(a, e);
      clr(a, e);
    end
    pulse('1);
    rd(7'h0e, 8'h68);
    clr(7'h0f, 8'h7f);
    clr(7'h10, 8'h3f);
    rd(7'h0e, 8'h00);
    for (int q = 0; q < 4; q++) begin
      wd = q[1:0];
      rd(7'h10, {q[1:0], 6'h00});
    end
    wd = 2'b00;
  endtask
  task automatic t_ov();
    ov_cfg = 1'b1;
    pulse(13'h0080);
    rd(7'h0f, 8'h00);
    ov_cfg = 1'b0;
    pulse(13'h0080);
    clr(7'h0f, 8'h02);
  endtask
  task automatic t_inputs();
    for (int b = 0; b < 3; b++) begin
      hi = 3'b001 << b;
      lo = 3'b001 << b;
      @(negedge clock);
      hi = 3'b000;
      lo = 3'b000;
      clr(7'h11, 8'h20 >> b);
    end
    hi = 3'b111;
    lo = 3'b111;
    node = 3'b111;
    @(negedge clock);
    hi = 3'b010;
    lo = 3'b000;
    rd(7'h11, 8'h3d);
    rd(7'h0e, 8'h10);
    clr(7'h11, 8'h3d);
    rd(7'h11, 8'h05);
    node = 3'b000;
  endtask
  task automatic t_gen();
    u_spi_master_model.xfer(16'h0000, 15, rx);
    rd(7'h0e, 8'h01);
    stop = 1'b1;
    @(negedge clock);
    rd(7'h0e, 8'h03);
    clr(7'h0e, 8'h03);
    rd(7'h0e, 8'h06);
    stop = 1'b0;
    clr(7'h0e, 8'h06);
    rd(7'h0e, 8'h04);
  endtask
  task automatic t_emf();
    emf = 3'b101;
    rd(7'h12, 8'h00);
    drv_en = 1'b1;
    rd(7'h12, 8'h05);
    u_spi_master_model.xfer({7'h2b, 1'b0, 8'hff}, 16, rx);
    rd(7'h2b, 8'h00);
    u_spi_master_model.xfer({7'h2b, 1'b1, 8'hff}, 16, rx);
    rd(7'h2b, 8'h07);
    chk("config pins", 8'h07, {5'h00, pp_en, blank_sel});
    repeat (200) @(negedge clock);
    for (int s = 0; s < 4; s++) begin
      u_spi_master_model.xfer({7'h2b, 1'b1, 6'h01, s[1:0]}, 16, rx);
      emf = ~emf;
      // snapshot lands a few cycles before the blanking ends
      repeat (blank[s] - 60) @(negedge clock);
      rd(7'h12, {5'h00, ~emf});
      rd(7'h12, {5'h00, emf});
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    rstn = 1'b0;
    stop = 1'b0;
    wd = 2'b00;
    hi = 3'b000;
    lo = 3'b000;
    node = 3'b000;
    emf = 3'b000;
    drv_en = 1'b0;
    ov_cfg = 1'b0;
    ev = '0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_faults();
    t_ov();
    t_inputs();
    t_gen();
    t_emf();
    finish_test();
  end
endmodule
